// ---- hdl/cfs_pkg.sv ----
// Package of flag word layout, segment selections and ALU operation codes
package cfs_pkg;

    localparam int FLAG_W      = 16;
    localparam int DATA_W      = 16;
    localparam int ADDR_W      = 20;
    localparam int SEG_SHIFT   = 4;
    localparam int DISP8_W     = 8;

    localparam int CF_POS      = 0;
    localparam int PF_POS      = 2;
    localparam int AF_POS      = 4;
    localparam int ZF_POS      = 6;
    localparam int SF_POS      = 7;
    localparam int TF_POS      = 8;
    localparam int IE_POS      = 9;
    localparam int DF_POS      = 10;
    localparam int OF_POS      = 11;

    localparam logic [15:0] FLAG_USED_MASK = 16'h0FD5;
    // Unassigned bits: bit 1 reads one, others zero
    localparam logic [15:0] FLAG_FIXED     = 16'h0002;
    localparam logic [15:0] FLAG_RESET     = 16'h0002;
    localparam logic [15:0] SEG_RESET_CODE = 16'hFFFF;
    localparam logic [15:0] SEG_RESET_OTH  = 16'h0000;

    typedef enum logic [1:0] {
        CFS_SEG_EXTRA = 2'h0,
        CFS_SEG_CODE  = 2'h1,
        CFS_SEG_STACK = 2'h2,
        CFS_SEG_DATA  = 2'h3
    } cfs_seg_t;

    typedef enum logic [1:0] {
        CFS_REF_FETCH  = 2'h0,
        CFS_REF_STACK  = 2'h1,
        CFS_REF_STRDST = 2'h2,
        CFS_REF_DATA   = 2'h3
    } cfs_ref_t;

    typedef enum logic [2:0] {
        CFS_OP_ADD = 3'h0,
        CFS_OP_ADC = 3'h1,
        CFS_OP_SUB = 3'h2,
        CFS_OP_SBB = 3'h3,
        CFS_OP_AND = 3'h4,
        CFS_OP_OR  = 3'h5,
        CFS_OP_XOR = 3'h6
    } cfs_op_t;

endpackage

// ---- hdl/cfs_addr_gen.sv ----
// Segmented physical address generator
`timescale 1ns/1ps
module cfs_addr_gen
    import cfs_pkg::*;
(
    input  wire logic [15:0] seg_base,
    input  wire logic [15:0] base_reg,
    input  wire logic [15:0] index_reg,
    input  wire logic [15:0] disp,
    input  wire logic        disp_is_8,
    input  wire logic        use_base,
    input  wire logic        use_index,
    output logic      [15:0] eff_offset,
    output logic      [19:0] phys_addr
);
    logic [15:0] disp_ext;
    logic [15:0] b_term;
    logic [15:0] i_term;

    always_comb begin
        disp_ext   = disp_is_8 ? {{(DATA_W-DISP8_W){disp[DISP8_W-1]}},
                                  disp[DISP8_W-1:0]} : disp;
        b_term     = use_base ? base_reg : 16'h0000;
        i_term     = use_index ? index_reg : 16'h0000;
        eff_offset = disp_ext + b_term + i_term;
        phys_addr  = {seg_base, {SEG_SHIFT{1'b0}}}
                   + {{SEG_SHIFT{1'b0}}, eff_offset};
    end
endmodule

// ---- hdl/cfs_core.sv ----
// Flag word register, segment registers and address generation for the core
`timescale 1ns/1ps
module cfs_core
    import cfs_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset,
    // ALU operation with flag update
    input  wire logic        alu_valid,
    input  wire logic [2:0]  alu_op,
    input  wire logic        alu_byte,
    input  wire logic [15:0] alu_a,
    input  wire logic [15:0] alu_b,
    // Flag word direct write and control
    input  wire logic        flag_wr,
    input  wire logic [15:0] flag_wdata,
    input  wire logic        instr_done,
    input  wire logic        irq_req,
    input  wire logic [7:0]  irq_vector,
    // Segment registers
    input  wire logic        seg_wr,
    input  wire logic [1:0]  seg_wsel,
    input  wire logic [15:0] seg_wdata,
    // Memory reference
    input  wire logic        ref_valid,
    input  wire logic [1:0]  ref_kind,
    input  wire logic        ovr_valid,
    input  wire logic [1:0]  ovr_seg,
    input  wire logic [15:0] base_reg,
    input  wire logic [15:0] index_reg,
    input  wire logic [15:0] disp,
    input  wire logic        disp_is_8,
    input  wire logic        use_base,
    input  wire logic        use_index,
    // String step
    input  wire logic        str_step,
    input  wire logic        str_word,
    input  wire logic [15:0] str_index,
    output logic [15:0]      flag_word,
    output logic [15:0]      alu_result,
    output logic [19:0]      phys_addr,
    output logic [1:0]       seg_used,
    output logic [15:0]      str_index_next,
    output logic             step_irq,
    output logic             mask_irq_take,
    output logic [7:0]       mask_irq_vector
);
    logic [15:0] flags;
    logic [15:0] next_flags;
    logic [15:0] seg_regs [4];
    logic [15:0] next_seg_regs [4];
    logic [15:0] result_q;
    logic [15:0] next_result;
    logic [19:0] addr_q;
    logic [19:0] next_addr;
    logic [1:0]  seg_q;
    logic [1:0]  next_seg_q;
    logic [15:0] str_q;
    logic [15:0] next_str;
    logic        step_pend;
    logic        next_step_pend;
    logic        step_q;
    logic        next_step;
    logic        take_q;
    logic        next_take;
    logic [7:0]  vec_q;
    logic [7:0]  next_vec;
    logic [19:0] gen_addr;
    logic [15:0] gen_off;
    logic [1:0]  sel_seg;

    // ALU arithmetic scratch
    logic [16:0] wide;
    logic [4:0]  nib;
    logic [15:0] res;
    logic        cin;
    logic        is_sub;
    logic        is_arith;
    logic        top_a;
    logic        top_b;
    logic        top_r;
    logic        carry;

    always_comb begin
        cin      = flags[CF_POS] && (alu_op == CFS_OP_ADC || alu_op == CFS_OP_SBB);
        is_sub   = (alu_op == CFS_OP_SUB) || (alu_op == CFS_OP_SBB);
        is_arith = (alu_op <= CFS_OP_SBB);
        wide     = 17'h00000;
        nib      = 5'h00;
        res      = 16'h0000;
        case (alu_op)
            CFS_OP_ADD, CFS_OP_ADC: begin
                wide = {1'b0, alu_a} + {1'b0, alu_b} + {16'h0000, cin};
                nib  = {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]} + {4'h0, cin};
            end
            CFS_OP_SUB, CFS_OP_SBB: begin
                wide = {1'b0, alu_a} - {1'b0, alu_b} - {16'h0000, cin};
                nib  = {1'b0, alu_a[3:0]} - {1'b0, alu_b[3:0]} - {4'h0, cin};
            end
            CFS_OP_AND: wide = {1'b0, alu_a & alu_b};
            CFS_OP_OR:  wide = {1'b0, alu_a | alu_b};
            CFS_OP_XOR: wide = {1'b0, alu_a ^ alu_b};
            default:    wide = 17'h00000;
        endcase
        res   = alu_byte ? {8'h00, wide[7:0]} : wide[15:0];
        top_a = alu_byte ? alu_a[7] : alu_a[15];
        top_b = (alu_byte ? alu_b[7] : alu_b[15]) ^ is_sub;
        top_r = alu_byte ? res[7] : res[15];
        // Byte carry or borrow is bit 8 of the wide result XORed with bit 8 of both operands
        carry = alu_byte ? (alu_a[8] ^ alu_b[8] ^ wide[8]) : wide[16];
    end

    // Flag word and step/interrupt sequencing
    always_comb begin
        next_flags     = flags;
        next_step_pend = step_pend;
        next_step      = 1'b0;
        next_take      = 1'b0;
        next_vec       = vec_q;
        next_result    = result_q;
        if (flag_wr) begin
            next_flags = (flag_wdata & FLAG_USED_MASK) | FLAG_FIXED;
        end
        if (alu_valid) begin
            next_result            = res;
            next_flags[CF_POS]     = is_arith && carry;
            next_flags[PF_POS]     = ~^res[7:0];
            next_flags[AF_POS]     = is_arith && nib[4];
            next_flags[ZF_POS]     = (res == 16'h0000);
            next_flags[SF_POS]     = top_r;
            next_flags[OF_POS]     = is_arith && (top_a == top_b) && (top_r != top_a);
        end
        if (instr_done) begin
            if (step_pend) begin
                next_step           = 1'b1;
                next_step_pend      = 1'b0;
                next_flags[TF_POS]  = 1'b0;
            end else begin
                next_step_pend      = flags[TF_POS];
                if (irq_req && flags[IE_POS]) begin
                    next_take = 1'b1;
                    next_vec  = irq_vector;
                end
            end
        end
        if (!flags[TF_POS] && !next_step) begin
            next_step_pend = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            flags     <= FLAG_RESET;
            step_pend <= 1'b0;
            step_q    <= 1'b0;
            take_q    <= 1'b0;
            vec_q     <= 8'h00;
            result_q  <= 16'h0000;
        end else begin
            flags     <= next_flags;
            step_pend <= next_step_pend;
            step_q    <= next_step;
            take_q    <= next_take;
            vec_q     <= next_vec;
            result_q  <= next_result;
        end
    end

    // Segment selection: override wins, else implicit by reference kind
    always_comb begin
        case (ref_kind)
            CFS_REF_FETCH:  sel_seg = CFS_SEG_CODE;
            CFS_REF_STACK:  sel_seg = CFS_SEG_STACK;
            CFS_REF_STRDST: sel_seg = CFS_SEG_EXTRA;
            default:        sel_seg = CFS_SEG_DATA;
        endcase
        if (ovr_valid) begin
            sel_seg = ovr_seg;
        end
    end

    cfs_addr_gen u_addr (
        .seg_base   (seg_regs[sel_seg]),
        .base_reg   (base_reg),
        .index_reg  (index_reg),
        .disp       (disp),
        .disp_is_8  (disp_is_8),
        .use_base   (use_base),
        .use_index  (use_index),
        .eff_offset (gen_off),
        .phys_addr  (gen_addr)
    );

    always_comb begin
        next_seg_q    = ref_valid ? sel_seg : seg_q;
        next_addr     = ref_valid ? gen_addr : addr_q;
        next_seg_regs = seg_regs;
        if (seg_wr) begin
            next_seg_regs[seg_wsel] = seg_wdata;
        end
        next_str   = str_q;
        if (str_step) begin
            if (flags[DF_POS]) begin
                next_str = str_index - (str_word ? 16'h0002 : 16'h0001);
            end else begin
                next_str = str_index + (str_word ? 16'h0002 : 16'h0001);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            seg_regs[CFS_SEG_EXTRA] <= SEG_RESET_OTH;
            seg_regs[CFS_SEG_CODE]  <= SEG_RESET_CODE;
            seg_regs[CFS_SEG_STACK] <= SEG_RESET_OTH;
            seg_regs[CFS_SEG_DATA]  <= SEG_RESET_OTH;
            addr_q                  <= 20'h00000;
            seg_q                   <= 2'h0;
            str_q                   <= 16'h0000;
        end else begin
            seg_regs <= next_seg_regs;
            addr_q   <= next_addr;
            seg_q    <= next_seg_q;
            str_q    <= next_str;
        end
    end

    assign flag_word       = flags;
    assign alu_result      = result_q;
    assign phys_addr       = addr_q;
    assign seg_used        = seg_q;
    assign str_index_next  = str_q;
    assign step_irq        = step_q;
    assign mask_irq_take   = take_q;
    assign mask_irq_vector = vec_q;
endmodule

// ---- dv/cfs_core_properties.sv ----
// Checker of flag word, segment choice, string step and interrupt timing
`timescale 1ns/1ps
module cfs_core_properties
    import cfs_pkg::*;
(
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        alu_valid,
    input wire logic [2:0]  alu_op,
    input wire logic        instr_done,
    input wire logic        irq_req,
    input wire logic [7:0]  irq_vector,
    input wire logic        ref_valid,
    input wire logic [1:0]  ref_kind,
    input wire logic        ovr_valid,
    input wire logic [1:0]  ovr_seg,
    input wire logic        str_step,
    input wire logic        str_word,
    input wire logic [15:0] str_index,
    input wire logic [15:0] flag_word,
    input wire logic [15:0] alu_result,
    input wire logic [1:0]  seg_used,
    input wire logic [15:0] str_index_next,
    input wire logic        step_irq,
    input wire logic        mask_irq_take,
    input wire logic [7:0]  mask_irq_vector
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // Step flag seen at a completion that did not fire, then two idle cycles
    sequence step_armed;
        instr_done && flag_word[TF_POS] ##1 !instr_done && !step_irq ##1 !instr_done;
    endsequence

    // Completion that follows the armed window
    sequence step_due;
        step_armed ##1 instr_done;
    endsequence

    fixed_bits_a: assert property (
        (flag_word & ~FLAG_USED_MASK) == FLAG_FIXED)
        else $error("unassigned flag bits changed");
    zero_flag_a: assert property (
        alu_valid |=> flag_word[ZF_POS] == (alu_result == 16'h0000))
        else $error("zero flag wrong");
    parity_flag_a: assert property (
        alu_valid |=> flag_word[PF_POS] == ~^alu_result[7:0])
        else $error("parity flag wrong");
    logic_clear_a: assert property (
        alu_valid && alu_op >= CFS_OP_AND |=> !flag_word[CF_POS] && !flag_word[OF_POS])
        else $error("logic op left carry or overflow");
    fetch_seg_a: assert property (
        ref_valid && !ovr_valid && ref_kind == 2'h0 |=> seg_used == CFS_SEG_CODE)
        else $error("fetch not on code segment");
    override_seg_a: assert property (
        ref_valid && ovr_valid |=> seg_used == $past(ovr_seg))
        else $error("override segment ignored");
    step_fire_a: assert property (
        step_due |=> step_irq && !flag_word[TF_POS])
        else $error("single step interrupt wrong");
    irq_take_a: assert property (
        instr_done && irq_req && flag_word[IE_POS] && !flag_word[TF_POS]
        |=> mask_irq_take && mask_irq_vector == $past(irq_vector))
        else $error("interrupt not taken");
    str_inc_a: assert property (
        str_step && !str_word && !flag_word[DF_POS] |=> str_index_next == $past(str_index) + 16'h0001)
        else $error("string index not incremented");
endmodule

// ---- dv/cfs_core_tb_top.sv ----
// Self-checking bench for the flag word and segmented addressing core
`timescale 1ns/1ps
module cfs_core_tb_top;
    import cfs_pkg::*;
    logic        mclk = 0, reset = 1, alu_valid = 0, alu_byte = 0, flag_wr = 0, instr_done = 0;
    logic        irq_req = 0, seg_wr = 0, ref_valid = 0, ovr_valid = 0, disp_is_8 = 0;
    logic        use_base = 1, use_index = 1, str_step = 0, str_word = 0, step_irq, mask_irq_take;
    logic [1:0]  seg_wsel = 0, ref_kind = 0, ovr_seg = 0, seg_used;
    logic [2:0]  alu_op = 0;
    logic [7:0]  irq_vector = 0, mask_irq_vector;
    logic [15:0] alu_a = 0, alu_b = 0, flag_wdata = 0, seg_wdata = 0, base_reg = 0, index_reg = 0;
    logic [15:0] disp = 0, str_index = 0, flag_word, alu_result, str_index_next;
    logic [19:0] phys_addr;
    int          fail_count = 0, num_checks = 0, cycles = 0;

    cfs_core DUT (.mclk, .reset, .alu_valid, .alu_op, .alu_byte, .alu_a, .alu_b, .flag_wr,
        .flag_wdata, .instr_done, .irq_req, .irq_vector, .seg_wr, .seg_wsel, .seg_wdata,
        .ref_valid, .ref_kind, .ovr_valid, .ovr_seg, .base_reg, .index_reg, .disp, .disp_is_8,
        .use_base, .use_index, .str_step, .str_word, .str_index, .flag_word, .alu_result,
        .phys_addr, .seg_used, .str_index_next, .step_irq, .mask_irq_take, .mask_irq_vector);

    always #12.5 mclk = ~mclk;

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            conclude();
        end
    end

    task automatic cyc(int n = 1);
        repeat (n) @(posedge mclk);
        #2;
    endtask

    task automatic chk(string name, logic [19:0] seen, logic [19:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic wflag(logic [15:0] v);
        flag_wdata = v;
        flag_wr = 1;
        cyc();
        flag_wr = 0;
        cyc();
    endtask

    // Valid stays high across back-to-back operations
    task automatic alu(logic [2:0] op, logic b8, logic [15:0] a, b, res, fl);
        alu_op = op;
        alu_byte = b8;
        alu_a = a;
        alu_b = b;
        alu_valid = 1;
        cyc();
        chk("alu_result", alu_result, res);
        chk("result_flags", flag_word & 16'h08D5, fl);
    endtask

    task automatic addr(logic [1:0] k, logic ov, logic [1:0] os, logic [15:0] b, i, d,
                        logic d8, logic [1:0] es, logic [19:0] ea);
        ref_kind = k;
        ovr_valid = ov;
        ovr_seg = os;
        base_reg = b;
        index_reg = i;
        disp = d;
        disp_is_8 = d8;
        ref_valid = 1;
        cyc();
        chk("seg_used", seg_used, es);
        chk("phys_addr", phys_addr, ea);
    endtask

    task automatic str(logic w, logic [15:0] i, exp);
        str_word = w;
        str_index = i;
        str_step = 1;
        cyc();
        chk("str_index_next", str_index_next, exp);
    endtask

    task automatic t_alu();
        alu(CFS_OP_ADD, 0, 16'h7FFF, 16'h0001, 16'h8000, 16'h0894);
        alu(CFS_OP_ADD, 0, 16'hFFFF, 16'h0001, 16'h0000, 16'h0055);
        alu(CFS_OP_ADC, 0, 16'h0001, 16'h0001, 16'h0003, 16'h0004);
        alu(CFS_OP_SUB, 0, 16'h0000, 16'h0001, 16'hFFFF, 16'h0095);
        alu(CFS_OP_SBB, 0, 16'h0005, 16'h0003, 16'h0001, 16'h0000);
        alu(CFS_OP_SUB, 1, 16'h1280, 16'h3401, 16'h007F, 16'h0810);
        alu(CFS_OP_AND, 0, 16'h0F0F, 16'h00FF, 16'h000F, 16'h0004);
        alu(CFS_OP_OR,  0, 16'h8000, 16'h0001, 16'h8001, 16'h0080);
        alu(CFS_OP_XOR, 0, 16'h1234, 16'h1234, 16'h0000, 16'h0044);
        alu(CFS_OP_ADD, 1, 16'h0080, 16'h0080, 16'h0000, 16'h0845);
        alu_valid = 0;
        cyc();
    endtask

    task automatic t_seg();
        for (int s = 0; s < 4; s++) begin
            seg_wsel = s[1:0];
            seg_wdata = 16'((s + 1) << 12);
            seg_wr = 1;
            cyc();
        end
        seg_wr = 0;
        addr(0, 0, 0, 16'h0010, 16'h0001, 16'h0080, 1, CFS_SEG_CODE, 20'h2FF91);
        addr(1, 0, 0, 16'h0010, 16'h0001, 16'h0080, 1, CFS_SEG_STACK, 20'h3FF91);
        addr(2, 0, 0, 16'h0010, 16'h0001, 16'h0080, 1, CFS_SEG_EXTRA, 20'h1FF91);
        addr(3, 0, 0, 16'h0010, 16'h0001, 16'h0080, 1, CFS_SEG_DATA, 20'h4FF91);
        addr(3, 1, 0, 16'h0010, 16'h0001, 16'h0080, 1, CFS_SEG_EXTRA, 20'h1FF91);
        addr(3, 0, 0, 16'hFFF0, 16'h0020, 16'h0000, 0, CFS_SEG_DATA, 20'h40010);
        addr(3, 0, 0, 16'h0000, 16'h0000, 16'h0080, 0, CFS_SEG_DATA, 20'h40080);
        // Unselected base or index must not enter the sum
        use_base = 0;
        addr(2, 0, 0, 16'h1234, 16'h0004, 16'h0000, 0, CFS_SEG_EXTRA, 20'h10004);
        use_base = 1;
        use_index = 0;
        addr(1, 0, 0, 16'h0010, 16'hFFFF, 16'h0000, 0, CFS_SEG_STACK, 20'h30010);
        use_index = 1;
        ref_valid = 0;
    endtask

    task automatic t_ctrl();
        wflag(16'hFFFF);
        chk("flag_word", flag_word, 16'h0FD7);
        wflag(16'h0000);
        str(0, 16'h0010, 16'h0011);
        str(1, 16'h0010, 16'h0012);
        str_step = 0;
        wflag(16'h0400);
        str(0, 16'h0010, 16'h000F);
        str(1, 16'h0000, 16'hFFFE);
        str_step = 0;
        wflag(16'h0100);
        instr_done = 1;
        cyc();
        instr_done = 0;
        chk("step_irq", step_irq, 0);
        cyc(2);
        instr_done = 1;
        cyc();
        instr_done = 0;
        chk("step_irq", step_irq, 1);
        chk("step_flag", flag_word[TF_POS], 0);
        wflag(16'h0200);
        irq_req = 1;
        irq_vector = 8'h5A;
        instr_done = 1;
        cyc();
        instr_done = 0;
        chk("mask_irq_take", mask_irq_take, 1);
        chk("mask_irq_vector", mask_irq_vector, 8'h5A);
        wflag(16'h0000);
        instr_done = 1;
        cyc();
        instr_done = 0;
        chk("mask_irq_take", mask_irq_take, 0);
    endtask

    // Reset for two edges, then check reset values and a first fetch
    task automatic t_reset();
        reset = 1;
        cyc(2);
        reset = 0;
        chk("flag_word", flag_word, 16'h0002);
        chk("alu_result", alu_result, 16'h0000);
        chk("phys_addr", phys_addr, 20'h00000);
        chk("str_index_next", str_index_next, 16'h0000);
        chk("mask_irq_vector", mask_irq_vector, 8'h00);
        addr(0, 0, 0, 16'h0000, 16'h0000, 16'h0020, 0, CFS_SEG_CODE, 20'h00010);
        ref_valid = 0;
    endtask

    initial begin
        cyc(8);
        t_reset();
        t_alu();
        t_seg();
        t_ctrl();
        t_reset();
        cyc(2);
        conclude();
    end
endmodule

bind cfs_core cfs_core_properties u_props (.mclk, .reset, .alu_valid, .alu_op, .instr_done,
    .irq_req, .irq_vector, .ref_valid, .ref_kind, .ovr_valid, .ovr_seg, .str_step, .str_word,
    .str_index, .flag_word, .alu_result, .seg_used, .str_index_next, .step_irq, .mask_irq_take,
    .mask_irq_vector);
